// ===== hdl/hbc_pkg.sv
// Package for the H-bridge decay chopper: bridge states, switch sets, timing counts.
// Assumes a 100 MHz system clock; all users reference names as hbc_pkg::name.
package hbc_pkg;

    // Clock period in nanoseconds.
    localparam int CLOCK_PERIOD_NS = 10;
    // Noise blanking after a charge start, typical and longest, in nanoseconds.
    localparam int BLANK_TYP_NS = 300;
    localparam int BLANK_MAX_NS = 500;
    // Typical blanking rounds up, and must stay within the longest time rounded down.
    localparam int BLANK_CYCLES = (BLANK_TYP_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int BLANK_MAX_CYCLES = BLANK_MAX_NS / CLOCK_PERIOD_NS;
    // Oscillator periods per chopping period.
    localparam int OSC_PER_CHOP = 8;
    // Fast decay share of the period is 37.5 percent, three of the eight slots.
    localparam int FAST_SLOTS = 3;
    // Reset value of the slot counter.
    localparam logic [2:0] SLOT_RESET = 3'h0;

    // Bridge drive state.
    typedef enum logic [1:0] {
        HBC_OFF,
        HBC_CHARGE,
        HBC_SLOW,
        HBC_FAST
    } hbc_bridge_type;

    // The four bridge switch gate commands.
    typedef struct packed {
        logic high_side_switch_a;
        logic high_side_switch_b;
        logic low_side_switch_a;
        logic low_side_switch_b;
    } hbc_switch_type;

    localparam hbc_switch_type SWITCH_ALL_OFF = 4'h0;

    // Controller inputs.
    typedef struct packed {
        logic phase;
        logic enable;
        logic standby_b;
        logic logic_supply_low;
        logic motor_supply_low;
    } hbc_ctrl_type;

endpackage

// ===== hdl/hbc_edge_detect.sv
// Rising-edge detector for the sawtooth ramp comparator.
// Assumes its input is already synchronous to clock.
`timescale 1ns/1ns
module hbc_edge_detect (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic level_in,
    output logic rise_pulse
);

    typedef struct packed {
        logic last;
        logic pulse;
    } hbc_edge_state_type;

    hbc_edge_state_type state_reg;
    hbc_edge_state_type state_next;

    // A pulse marks the rising portion of the ramp.
    always_comb begin
        state_next = state_reg;
        state_next.last = level_in;
        state_next.pulse = level_in & ~state_reg.last;
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign rise_pulse = state_reg.pulse;

endmodule

// ===== hdl/hbc_bridge_map.sv
// Maps bridge state and current direction to the four switch gates.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ns
module hbc_bridge_map (
    input wire hbc_pkg::hbc_bridge_type bridge,
    input wire logic forward,
    output hbc_pkg::hbc_switch_type switches
);

    // Slow decay is the same both ways; charge and fast swap diagonals with direction.
    always_comb begin
        switches = hbc_pkg::SWITCH_ALL_OFF;
        case (bridge)
            hbc_pkg::HBC_CHARGE: begin
                if (forward) begin
                    switches = 4'b1001; // RULE1
                end else begin
                    switches = 4'b0110; // RULE2
                end
            end
            hbc_pkg::HBC_SLOW: begin
                switches = 4'b0011; // RULE4
            end
            hbc_pkg::HBC_FAST: begin
                if (forward) begin
                    switches = 4'b0110; // RULE1
                end else begin
                    switches = 4'b1001; // RULE2
                end
            end
            default: begin
                switches = hbc_pkg::SWITCH_ALL_OFF; // RULE5
            end
        endcase
    end

endmodule

// ===== hdl/hbc_chopper.sv
// Chopper logic for one H-bridge of a bipolar stepper driver.
// Assumes all inputs are synchronous to clock, and that osc_ramp_high is the
// comparator output of the external sawtooth, high on its rising portion.
//
// Contract
// [RULE1] Forward: charge A-high/B-low, fast B-high/A-low.
// [RULE2] Reverse: charge B-high/A-low, fast A-high/B-low.
// [RULE3] Bridge states change autonomously to regulate current.
// [RULE4] Decay drives switches, never relies on diodes.
// [RULE5] Forced off turns every switch off.
// [RULE6] Low logic supply forces internal reset.
// [RULE7] Low motor supply forces internal reset.
// [RULE8] Zero logic supply holds outputs off.
// [RULE9] Controller keeps standby until motor supply adequate.
// [RULE10] Controller waits charge pump settling after power-up.
// [RULE11] One chop period per eight oscillator periods.
// [RULE12] Oscillator clock from sawtooth rising portion.
// [RULE13] Half-step: controller sets peak for full torque.
// [RULE14] Fast decay takes 37.5 percent of period.
// [RULE15] Comparator ignored during blanking after charge start.
// [RULE16] Controller waits pump rise time after standby.
// [RULE17] Period starts charging; comparator trip ends charge.
// [RULE18] Reset or standby holds off, restart charging.
//
// Operating notes.
// The block sequences one bridge through charge, slow decay and fast decay.
// Each chopping period is eight slots long, and a slot is one sawtooth rise.
// A period always opens in charge, with the sense comparator blanked.
// Blanking lasts BLANK_LEN clock cycles, counted down in the state register.
// Once blanking has run out, a comparator trip ends charge for the period.
// After a trip the bridge sits in slow decay until the fast decay slots.
// The last FAST_SHARE slots of every period are spent in fast decay.
// Fast decay is entered even without a trip, so the ripple stays bounded.
// That costs some average current at light load, which we accept here.
// The direction input is registered every cycle along with the bridge state.
// A direction change inside a period swaps the diagonals at the next edge.
// We do not insert dead time here; the gate drivers are expected to add it.
// Every gate command comes straight from a flip-flop, so no glitch reaches a gate.
// The map from state to gates is combinational and feeds that flip-flop.
// A dropped enable, standby or either supply monitor is called a halt.
// A halt turns every gate off at the next edge, whatever the period was doing.
// While halted, the slot counter, trip flag and blanking counter are cleared.
// Releasing the halt opens a fresh period in charge at the next edge.
// The period timing therefore restarts and is not aligned to the old one.
// The internal reset output is only the registered OR of both supply monitors.
// Standby and enable stop the bridge but do not raise the internal reset.
// The supply monitors are assumed to be filtered and synchronous already.
// The oscillator clock output is a one-cycle pulse per sawtooth rise.
// It trails the rise of the ramp comparator by two clock cycles.
// The slot counter advances on the same internal tick, at the same edge as the output pulse.
// A ramp that is high through reset gives one spurious tick after release.
// That tick is harmless, because the bridge is halted during start-up.
// The sense comparator is ignored outside charge, as it means nothing there.
// The blanking length must stay within the longest allowed blanking time.
// With a fast ramp, one slot must outlast blanking, or trips are lost.
// The controller owns the start-up waits for the charge pump.
// The controller also owns the torque and current level settings.
// Neither of those waits is enforced here; the bridge obeys the inputs.
// Shoot-through is impossible by construction of the gate map.
// The assertions below guard the map, the timing and the halt behaviour.
// The cover properties show that slow decay, reverse fast decay and reverse charge are really reached.
`timescale 1ns/1ns
module hbc_chopper #(
    parameter int OSC_DIV = hbc_pkg::OSC_PER_CHOP,
    parameter int FAST_SHARE = hbc_pkg::FAST_SLOTS,
    parameter int BLANK_LEN = hbc_pkg::BLANK_CYCLES
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire hbc_pkg::hbc_ctrl_type ctrl,
    input wire logic osc_ramp_high,
    input wire logic current_trip,
    output hbc_pkg::hbc_switch_type switches,
    output logic osc_derived_clock,
    output logic chop_start,
    output logic internal_reset
);

    localparam int SLOT_W = $clog2(OSC_DIV);
    localparam int BLANK_W = $clog2(BLANK_LEN + 1);
    localparam logic [SLOT_W-1:0] SLOT_LAST = SLOT_W'(OSC_DIV - 1);
    localparam logic [SLOT_W-1:0] FAST_FROM = SLOT_W'(OSC_DIV - FAST_SHARE);
    localparam logic [BLANK_W-1:0] BLANK_LOAD = BLANK_W'(BLANK_LEN);

    typedef struct packed {
        hbc_pkg::hbc_bridge_type bridge;
        logic [SLOT_W-1:0] slot;
        logic [BLANK_W-1:0] blank;
        logic tripped;
        logic running;
        logic forward;
        hbc_pkg::hbc_switch_type switches;
        logic osc_clk;
        logic chop_start;
        logic internal_reset;
    } hbc_state_type;

    // Registered state and its next value.
    hbc_state_type state_reg;
    hbc_state_type state_next;
    // One-cycle pulse for each sawtooth rise.
    logic osc_tick;
    // High while anything forces the bridge off.
    logic halt;
    // Gate set for the next bridge state, before the halt override.
    hbc_pkg::hbc_switch_type map_out;

    // Oscillator clock taken from the sawtooth rise.
    hbc_edge_detect u_edge (
        .clock(clock),
        .rst_b(rst_b),
        .level_in(osc_ramp_high), // RULE12
        .rise_pulse(osc_tick)
    );

    hbc_bridge_map u_map (
        .bridge(state_next.bridge),
        .forward(state_next.forward),
        .switches(map_out)
    );

    // Either supply monitor, standby or a dropped enable stops the bridge.
    assign halt = ctrl.logic_supply_low | ctrl.motor_supply_low | ~ctrl.standby_b | ~ctrl.enable;

    // Chopping sequencer: charge until trip, slow decay, then the last slots in fast decay.
    always_comb begin
        state_next = state_reg;
        state_next.chop_start = 1'b0;
        state_next.osc_clk = osc_tick; // RULE12
        state_next.internal_reset = ctrl.logic_supply_low | ctrl.motor_supply_low; // RULE6 RULE7 RULE8
        state_next.forward = ctrl.phase;
        // The blanking counter runs down on its own and rests at zero.
        if (state_reg.blank != '0) begin
            state_next.blank = state_reg.blank - 1'b1; // RULE15
        end
        // A halt wins over everything else, so no gate stays on.
        if (halt) begin
            state_next.bridge = hbc_pkg::HBC_OFF; // RULE5 RULE18
            state_next.running = 1'b0;
            state_next.slot = hbc_pkg::SLOT_RESET;
            state_next.tripped = 1'b0;
            state_next.blank = '0;
        end else if (!state_reg.running || (osc_tick && state_reg.slot == SLOT_LAST)) begin
            // A new period always opens with charge; the trip flag clears here.
            state_next.running = 1'b1;
            state_next.slot = hbc_pkg::SLOT_RESET; // RULE11
            state_next.bridge = hbc_pkg::HBC_CHARGE; // RULE17 RULE18
            state_next.tripped = 1'b0;
            state_next.blank = BLANK_LOAD; // RULE15
            state_next.chop_start = 1'b1;
        end else begin
            // Inside a period the slot only moves on a ramp tick.
            if (osc_tick) begin
                state_next.slot = state_reg.slot + 1'b1; // RULE11
            end
            // Comparator only counts once the blanking window has expired.
            if (current_trip && state_reg.blank == '0 && state_reg.bridge == hbc_pkg::HBC_CHARGE) begin
                state_next.tripped = 1'b1; // RULE17
            end
            if (state_next.slot >= FAST_FROM) begin
                state_next.bridge = hbc_pkg::HBC_FAST; // RULE14 RULE3
            end else if (state_next.tripped) begin
                state_next.bridge = hbc_pkg::HBC_SLOW; // RULE3 RULE4
            end else begin
                state_next.bridge = hbc_pkg::HBC_CHARGE;
            end
        end
        state_next.switches = halt ? hbc_pkg::SWITCH_ALL_OFF : map_out; // RULE5
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign switches = state_reg.switches;
    assign osc_derived_clock = state_reg.osc_clk;
    assign chop_start = state_reg.chop_start;
    assign internal_reset = state_reg.internal_reset;

    // Checks on the registered behaviour.
    a_halt_all_off: assert property (@(posedge clock) disable iff (!rst_b) // RULE5
        halt |=> switches == hbc_pkg::SWITCH_ALL_OFF)
        else $error("Bridge not off while halted.");
    a_supply_reset: assert property (@(posedge clock) disable iff (!rst_b) // RULE6
        ctrl.logic_supply_low |=> internal_reset && switches == hbc_pkg::SWITCH_ALL_OFF)
        else $error("Logic supply low did not reset.");
    a_motor_reset: assert property (@(posedge clock) disable iff (!rst_b) // RULE7
        ctrl.motor_supply_low |=> internal_reset && switches == hbc_pkg::SWITCH_ALL_OFF)
        else $error("Motor supply low did not reset.");
    a_no_shoot: assert property (@(posedge clock) disable iff (!rst_b) // RULE1
        !(switches.high_side_switch_a && switches.low_side_switch_a)
        && !(switches.high_side_switch_b && switches.low_side_switch_b))
        else $error("Shoot-through on a bridge leg.");
    a_start_charge: assert property (@(posedge clock) disable iff (!rst_b) // RULE17
        chop_start |-> switches == (state_reg.forward ? 4'b1001 : 4'b0110))
        else $error("Period did not open in charge.");
    a_blank_hold: assert property (@(posedge clock) disable iff (!rst_b) // RULE15
        chop_start && !halt |=> state_reg.bridge == hbc_pkg::HBC_CHARGE)
        else $error("Charge left during blanking.");
    a_period_len: assert property (@(posedge clock) disable iff (!rst_b) // RULE11
        state_reg.running && osc_tick && state_reg.slot == SLOT_LAST && !halt |=> chop_start)
        else $error("Period did not end after eight ticks.");
    a_fast_share: assert property (@(posedge clock) disable iff (!rst_b) // RULE14
        state_reg.running && !halt && state_reg.slot >= FAST_FROM && !state_next.chop_start
        |=> state_reg.bridge == hbc_pkg::HBC_FAST)
        else $error("Fast decay slot not honoured.");
    a_trip_decay: assert property (@(posedge clock) disable iff (!rst_b) // RULE3
        state_reg.tripped && state_reg.running |-> state_reg.bridge != hbc_pkg::HBC_CHARGE)
        else $error("Charge held after trip.");
    // Forward charge drives the high A and low B gates.
    a_fwd_charge: assert property (@(posedge clock) disable iff (!rst_b) // RULE1
        state_reg.bridge == hbc_pkg::HBC_CHARGE && state_reg.forward |-> switches == 4'b1001)
        else $error("Forward charge gates wrong.");
    // Reverse charge drives the high B and low A gates.
    a_rev_charge: assert property (@(posedge clock) disable iff (!rst_b) // RULE2
        state_reg.bridge == hbc_pkg::HBC_CHARGE && !state_reg.forward |-> switches == 4'b0110)
        else $error("Reverse charge gates wrong.");
    // Forward fast decay drives the opposite diagonal.
    a_fwd_fast: assert property (@(posedge clock) disable iff (!rst_b) // RULE1
        state_reg.bridge == hbc_pkg::HBC_FAST && state_reg.forward |-> switches == 4'b0110)
        else $error("Forward fast decay gates wrong.");
    // Reverse fast decay drives the opposite diagonal.
    a_rev_fast: assert property (@(posedge clock) disable iff (!rst_b) // RULE2
        state_reg.bridge == hbc_pkg::HBC_FAST && !state_reg.forward |-> switches == 4'b1001)
        else $error("Reverse fast decay gates wrong.");
    // Slow decay keeps both low gates on, so the diodes carry nothing.
    a_slow_lows: assert property (@(posedge clock) disable iff (!rst_b) // RULE4
        state_reg.bridge == hbc_pkg::HBC_SLOW |-> switches == 4'b0011)
        else $error("Slow decay gates wrong.");
    // The off state really leaves every gate off.
    a_off_gates: assert property (@(posedge clock) disable iff (!rst_b) // RULE5
        state_reg.bridge == hbc_pkg::HBC_OFF |-> switches == hbc_pkg::SWITCH_ALL_OFF)
        else $error("Gate on in off state.");
    // No gate is on while the internal reset stands.
    a_reset_gates: assert property (@(posedge clock) disable iff (!rst_b) // RULE8
        internal_reset |-> switches == hbc_pkg::SWITCH_ALL_OFF)
        else $error("Gate on during internal reset.");
    // The internal reset clears once both supplies are good.
    a_reset_clear: assert property (@(posedge clock) disable iff (!rst_b) // RULE7
        !ctrl.logic_supply_low && !ctrl.motor_supply_low |=> !internal_reset)
        else $error("Internal reset held with good supplies.");
    // The oscillator clock follows every ramp rise two cycles later.
    a_tick_follow: assert property (@(posedge clock) disable iff (!rst_b) // RULE12
        $rose(osc_ramp_high) |-> ##2 osc_derived_clock)
        else $error("Ramp rise gave no oscillator clock.");
    // The oscillator clock is a single-cycle pulse.
    a_tick_pulse: assert property (@(posedge clock) disable iff (!rst_b) // RULE12
        osc_derived_clock |=> !osc_derived_clock)
        else $error("Oscillator clock longer than one cycle.");
    // Each period loads the full blanking count.
    a_blank_load: assert property (@(posedge clock) disable iff (!rst_b) // RULE15
        chop_start |-> state_reg.blank == BLANK_LOAD)
        else $error("Blanking not loaded at period start.");
    // Blanking never exceeds the longest allowed time.
    a_blank_max: assert property (@(posedge clock) disable iff (!rst_b) // RULE15
        int'(state_reg.blank) <= hbc_pkg::BLANK_MAX_CYCLES)
        else $error("Blanking longer than allowed.");
    // A trip inside blanking must not end charge.
    a_blank_ignore: assert property (@(posedge clock) disable iff (!rst_b) // RULE15
        state_reg.blank != '0 && !halt && !state_reg.tripped |=> state_reg.bridge != hbc_pkg::HBC_SLOW)
        else $error("Trip accepted during blanking.");
    // A trip after blanking ends charge at the next edge.
    a_trip_ends: assert property (@(posedge clock) disable iff (!rst_b) // RULE17
        current_trip && state_reg.blank == '0 && state_reg.bridge == hbc_pkg::HBC_CHARGE
        && !halt && !state_next.chop_start |=> state_reg.bridge != hbc_pkg::HBC_CHARGE)
        else $error("Trip did not end charge.");
    // Before a trip and before the fast slots the bridge charges.
    a_charge_held: assert property (@(posedge clock) disable iff (!rst_b) // RULE17
        state_reg.running && state_reg.slot < FAST_FROM && !state_reg.tripped
        |-> state_reg.bridge == hbc_pkg::HBC_CHARGE)
        else $error("Charge left without a trip.");
    // Fast decay only appears in the late slots.
    a_fast_late: assert property (@(posedge clock) disable iff (!rst_b) // RULE14
        state_reg.bridge == hbc_pkg::HBC_FAST |-> state_reg.slot >= FAST_FROM)
        else $error("Fast decay in an early slot.");
    // Standby stops the bridge and opens no period.
    a_standby_off: assert property (@(posedge clock) disable iff (!rst_b) // RULE18
        !ctrl.standby_b |=> switches == hbc_pkg::SWITCH_ALL_OFF && !chop_start)
        else $error("Bridge active in standby.");
    // Leaving the off state always opens a period.
    a_restart: assert property (@(posedge clock) disable iff (!rst_b) // RULE18
        state_reg.bridge == hbc_pkg::HBC_OFF && !halt |=> chop_start)
        else $error("No restart after release.");
    // Period starts are single pulses.
    a_chop_once: assert property (@(posedge clock) disable iff (!rst_b) // RULE11
        chop_start |=> !chop_start)
        else $error("Period start longer than one cycle.");
    // The slot counter only moves on a ramp tick.
    a_slot_hold: assert property (@(posedge clock) disable iff (!rst_b) // RULE11
        !osc_tick && !halt |=> $stable(state_reg.slot))
        else $error("Slot moved without a tick.");
    c_trip: cover property (@(posedge clock) disable iff (!rst_b)
        state_reg.bridge == hbc_pkg::HBC_SLOW);
    c_fast: cover property (@(posedge clock) disable iff (!rst_b)
        state_reg.bridge == hbc_pkg::HBC_FAST && !state_reg.forward);
    c_restart: cover property (@(posedge clock) disable iff (!rst_b)
        halt ##1 !halt ##1 chop_start);
    c_reverse_charge: cover property (@(posedge clock) disable iff (!rst_b)
        state_reg.bridge == hbc_pkg::HBC_CHARGE && !state_reg.forward);
    c_supply_reset: cover property (@(posedge clock) disable iff (!rst_b)
        internal_reset);

endmodule

// ===== bench/hbc_winding_model.sv
// Winding model: a signed coil current moved by the four bridge gates.
// Assumes the gate set is registered on clock; positive current is forward.
`timescale 1ns/1ns
module hbc_winding_model (
    input wire logic clock,
    input wire logic rst_b,
    input wire hbc_pkg::hbc_switch_type switches,
    input wire logic [9:0] level,
    output logic current_trip
);
    int cur_reg;
    int drive;
    // Supply polarity across the coil; zero in slow decay or with all gates off.
    assign drive = (switches == 4'h9) ? 1 : ((switches == 4'h6) ? -1 : 0);
    // An opposing supply drains fast and clamps at zero, but a fast decay that lasts past zero then drives the coil the other way.
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            cur_reg <= 0;
        end else if (drive != 0 && (cur_reg == 0 || (cur_reg > 0) == (drive > 0))) begin
            cur_reg <= cur_reg + 2 * drive;
        end else if (cur_reg > 0) begin
            cur_reg <= (drive != 0) ? ((cur_reg > 4) ? cur_reg - 4 : 0) : cur_reg - 1;
        end else if (cur_reg < 0) begin
            cur_reg <= (drive != 0) ? ((cur_reg < -4) ? cur_reg + 4 : 0) : cur_reg + 1;
        end
    end
    // The sense comparator sees the current magnitude.
    assign current_trip = ((cur_reg < 0) ? -cur_reg : cur_reg) >= int'(level);
endmodule

// ===== bench/tb.sv
// Testbench for the chopper: sawtooth source, controller stimulus, winding model.
// Assumes one 100 MHz clock and a synchronous active-low reset.
`timescale 1ns/1ns
module tb;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    hbc_pkg::hbc_ctrl_type ctrl = 5'h00;
    logic osc_ramp_high;
    logic current_trip;
    logic [9:0] level = 10'h000;
    logic [5:0] ramp_cnt = 6'h00;
    hbc_pkg::hbc_switch_type switches;
    logic osc_derived_clock;
    logic chop_start;
    logic internal_reset;
    int n_errors = 0;
    int check_count = 0;

    hbc_chopper i_hbc_chopper (.clock(clock), .rst_b(rst_b), .ctrl(ctrl), .osc_ramp_high(osc_ramp_high),
        .current_trip(current_trip), .switches(switches), .osc_derived_clock(osc_derived_clock),
        .chop_start(chop_start), .internal_reset(internal_reset));
    hbc_winding_model i_hbc_winding_model (.clock(clock), .rst_b(rst_b), .switches(switches),
        .level(level), .current_trip(current_trip));

    // Clock of 10 ns.
    always #5 clock = ~clock;
    // Ramp of 40 cycles, so one slot outlasts the blanking time.
    always @(negedge clock) ramp_cnt <= (ramp_cnt == 6'h27) ? 6'h00 : ramp_cnt + 6'h01;
    assign osc_ramp_high = ramp_cnt < 6'h14;

    // Counts a comparison and reports a mismatch at once.
    task automatic check(input logic [3:0] got, input logic [3:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Expected gates for 1 charge, 2 slow, 3 fast.
    function automatic logic [3:0] exp_sw(input int st, input logic fwd);
        case (st)
            1: return fwd ? 4'h9 : 4'h6;
            2: return 4'h3;
            3: return fwd ? 4'h6 : 4'h9;
            default: return 4'h0;
        endcase
    endfunction

    // Waits up to 1000 cycles for a period to open.
    task automatic wait_chop();
        int n = 0;
        do begin
            @(negedge clock);
            n++;
        end while (chop_start !== 1'b1 && n < 1000);
        check({3'h0, chop_start}, 4'h1);
    endtask

    // One period: charge first, blanking, decay order and eight ramp ticks.
    task automatic run_period(input logic ph, input int lvl);
        int c = 0;
        int t = 0;
        int r = 0;
        int f = 0;
        logic ok;
        logic slow_seen = 1'b0;
        ctrl.phase = ph;
        level = 10'(lvl);
        wait_chop();
        check(switches, exp_sw(1, ph));
        do begin
            @(negedge clock);
            c++;
            t += (osc_derived_clock === 1'b1) ? 1 : 0;
            r += (ramp_cnt == 6'h00) ? 1 : 0;
            if (switches === exp_sw(2, ph)) slow_seen = 1'b1;
            if (t == 5 && f == 0) f = c;
            ok = (switches === exp_sw(1, ph)) || (switches === exp_sw(2, ph));
            if (t < 5) check({3'h0, ok}, 4'h1);
            if (f > 0 && c == f + 3) check(switches, exp_sw(3, ph));
            if (lvl == 0 && c == 25) check(switches, exp_sw(1, ph));
            if (lvl == 0 && c == 38) check(switches, exp_sw(2, ph));
        end while (chop_start !== 1'b1 && c < 1000);
        check(4'(t), 4'h8);
        check(4'(r), 4'h8);
        if (lvl < 100) check({3'h0, slow_seen}, 4'h1);
    endtask

    // Forces the bridge off by one of four causes, then releases it.
    task automatic force_off(input int k);
        hbc_pkg::hbc_ctrl_type saved;
        int hold;
        saved = ctrl;
        hold = 10 + $urandom_range(40);
        case (k)
            0: ctrl.enable = 1'b0;
            1: ctrl.standby_b = 1'b0;
            2: ctrl.logic_supply_low = 1'b1;
            default: ctrl.motor_supply_low = 1'b1;
        endcase
        repeat (2) @(negedge clock);
        check(switches, 4'h0);
        if (k >= 2) check({3'h0, internal_reset}, 4'h1);
        repeat (hold) @(negedge clock);
        check(switches, 4'h0);
        ctrl = saved;
        wait_chop();
        check(switches, exp_sw(1, ctrl.phase));
        check({3'h0, internal_reset}, 4'h0);
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Main sequence; standby is held through start-up so the gates never see a weak pump.
    initial begin
        void'($urandom(32'h1A43));
        repeat (16) @(negedge clock);
        rst_b = 1'b1;
        @(negedge clock);
        check(switches, 4'h0);
        repeat (20) @(negedge clock);
        ctrl.standby_b = 1'b1;
        repeat (20) @(negedge clock);
        check(switches, 4'h0);
        ctrl.enable = 1'b1;
        $display("test reset done");
        for (int i = 0; i < 2; i++) run_period(i[0], 0);
        $display("test blanking done");
        for (int i = 0; i < 6; i++) run_period(1'($urandom_range(1)), $urandom_range(99, 1));
        $display("test random periods done");
        for (int i = 0; i < 4; i++) begin
            ctrl.phase = 1'($urandom_range(1));
            force_off(i);
        end
        $display("test forced off done");
        close_out();
    end

    // The run needs about 5000 cycles; 50000 means a hang.
    initial begin
        #500000;
        n_errors++;
        $display("MISMATCH at %0t: got %h expected %h", $time, 1'b0, 1'b1);
        close_out();
    end
endmodule
